// *** src/load_diag_cfg.svh ***
// Register offsets, field positions, reset values and timing counts for the load diagnostics bank
//==========================================================================
// Notes on behaviour
// - Ch3/ch4 short thresholds, 0.5 ohm steps, reset 1 ohm
// - Threshold register read-write at 0x0B, reset 0x11
// - Result register 0x0C holds ch1 and ch2
// - Result register 0x0D holds ch3 and ch4
// - Ground-short flag set on short to ground
// - Power-short flag set on short to supply
// - Open-load and below-threshold flags per channel
// - Line-output flags in bits 3..0, upper zero
// - Two-bit state read-back per channel
// - State read-back read-only at 0x0F, reset 0x55
// - Overcurrent flags in bits 7..4
// - DC-offset flags in bits 3..0
// - Result and fault registers read-only, reset zero
// - Auto diagnostics on leaving high impedance, faults
// - Line-output results only while enable set
// - Abort stops run; software clears abort bit
`ifndef LOAD_DIAG_CFG_SVH
`define LOAD_DIAG_CFG_SVH

`define ADDR_THRESH_34     8'h0B
`define ADDR_RESULT_12     8'h0C
`define ADDR_RESULT_34     8'h0D
`define ADDR_LINE_OUT      8'h0E
`define ADDR_STATE_RB      8'h0F
`define ADDR_CH_FAULT      8'h10

`define RST_THRESH_34      8'h11
`define RST_STATE_RB       8'h55
`define RST_ZERO           8'h00
`define RST_STATE_CODE     2'h1

`define DIAG_RUN_NS        1000
`define CLK_PERIOD_NS      8
`define DIAG_RUN_CYC       ((`DIAG_RUN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** src/load_diag_pkg.sv ***
// Types shared by the load diagnostics register bank
package load_diag_pkg;
   typedef enum logic [1:0] {
      ST_PLAY = 2'h0,
      ST_HIZ  = 2'h1,
      ST_MUTE = 2'h2,
      ST_DIAG = 2'h3
   } chan_state_t;

   typedef enum logic [2:0] {
      CS_IDLE = 3'b001,
      CS_RUN  = 3'b010,
      CS_DONE = 3'b100
   } diag_fsm_t;
endpackage

// *** src/chan_diag_seq.sv ***
// One channel's DC diagnostic sequencer and result holder
`include "load_diag_cfg.svh"
module chan_diag_seq
   import load_diag_pkg::*;
#(
   parameter int RUN_CYC = `DIAG_RUN_CYC
) (
   input  wire logic       sys_clk,        // 125 MHz control clock
   input  wire logic       rst_b,          // Async reset, active low
   input  wire logic [1:0] req_state,      // Requested channel state
   input  wire logic       auto_diag_disable, // Suppress automatic runs
   input  wire logic       diag_abort_request, // Stop a run in progress
   input  wire logic       line_diag_enable,   // Line-output detection enabled
   input  wire logic       fault_seen,     // Channel fault level (synced)
   input  wire logic [3:0] short_threshold,// Shorted-load threshold code
   input  wire logic [3:0] meas_load,      // Measured load, threshold units
   input  wire logic [3:0] meas_flags,     // Ground, power, open, line-out
   output logic [3:0]      result,         // Ground, power, open, shorted
   output logic            line_out,       // Line output found
   output logic [1:0]      state_rb        // Actual state
);
   diag_fsm_t        fsm;
   diag_fsm_t        next_fsm;
   logic [1:0]       prev_req;
   logic             prev_fault;
   logic [15:0]      cnt;

   wire leave_hiz  = (prev_req == ST_HIZ) && (req_state != ST_HIZ);
   wire new_fault  = fault_seen && !prev_fault;
   wire auto_start = !auto_diag_disable && (leave_hiz || new_fault);
   wire start      = (req_state == ST_DIAG && prev_req != ST_DIAG) || auto_start;
   wire run_end    = (cnt == 16'(RUN_CYC - 1));

   always_comb begin
      case (fsm)
         CS_IDLE: next_fsm = (start && !diag_abort_request) ? CS_RUN : CS_IDLE;
         CS_RUN:  next_fsm = diag_abort_request ? CS_IDLE :
                             (run_end ? CS_DONE : CS_RUN);
         CS_DONE: next_fsm = CS_IDLE;
         default: next_fsm = CS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fsm        <= CS_IDLE;
         prev_req   <= `RST_STATE_CODE;
         prev_fault <= 1'b0;
         cnt        <= 16'h0000;
      end else begin
         fsm        <= next_fsm;
         prev_req   <= req_state;
         prev_fault <= fault_seen;
         cnt        <= (fsm == CS_RUN) ? cnt + 16'h0001 : 16'h0000;
      end
   end

   // Results change only at run completion; an aborted run keeps old results
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         result   <= 4'h0;
         line_out <= 1'b0;
      end else if (fsm == CS_RUN && run_end && !diag_abort_request) begin
         result   <= {meas_flags[3],
                      meas_flags[2],
                      meas_flags[1],
                      !meas_flags[1] && (meas_load < short_threshold)};
         line_out <= line_diag_enable && meas_flags[0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_rb <= `RST_STATE_CODE;
      end else begin
         state_rb <= (next_fsm == CS_RUN) ? ST_DIAG :
                     ((req_state == ST_DIAG) ? ST_HIZ : req_state);
      end
   end
endmodule

// *** src/load_diag_regs.sv ***
// Load diagnostic threshold, result, state and channel fault register bank
`include "load_diag_cfg.svh"
module load_diag_regs
   import load_diag_pkg::*;
#(
   parameter int RUN_CYC = `DIAG_RUN_CYC
) (
   input  wire logic       sys_clk,            // 125 MHz control clock
   input  wire logic       rst_b,              // Async reset, active low
   input  wire logic [7:0] reg_addr,           // Register address from control port
   input  wire logic       reg_wr,             // Write strobe, one cycle
   input  wire logic [7:0] reg_wdata,          // Write data
   input  wire logic       reg_rd,             // Read strobe, one cycle
   output logic [7:0]      reg_rdata,          // Read data, valid cycle after strobe
   input  wire logic [7:0] chan_state_req,     // Requested states, ch1 in 7:6
   input  wire logic       auto_diag_disable,  // Automatic diagnostics off
   input  wire logic       diag_abort_request, // Abort diagnostics
   input  wire logic       line_diag_enable,   // Line-output detection on
   input  wire logic [15:0] meas_load,         // Measured load per ch, ch1 in 15:12
   input  wire logic [15:0] meas_flags,        // Gnd,pwr,open,line per ch, ch1 top
   input  wire logic [3:0] overcurrent_in,     // Overcurrent pins, ch1 in bit 3
   input  wire logic [3:0] dc_fault_in,        // DC offset pins, ch1 in bit 3
   input  wire logic [7:0] thresh_ch1_ch2,     // Ch1/ch2 thresholds from elsewhere
   output logic [7:0]      short_threshold     // Ch3/ch4 threshold register
);
   //==========================================================================
   // Fault input synchronisers
   logic [7:0] f_s1;
   logic [7:0] f_s2;
   logic [7:0] f_s3;
   logic [7:0] f_stable;
   wire  [7:0] f_raw = {overcurrent_in, dc_fault_in};

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         f_s1     <= `RST_ZERO;
         f_s2     <= `RST_ZERO;
         f_s3     <= `RST_ZERO;
         f_stable <= `RST_ZERO;
      end else begin
         f_s1     <= f_raw;
         f_s2     <= f_s1;
         f_s3     <= f_s2;
         f_stable <= (f_s2 & f_s3) | (f_stable & (f_s2 | f_s3));
      end
   end

   //==========================================================================
   // Per-channel sequencers
   logic [15:0] results;
   logic [3:0]  line_found;
   logic [7:0]  state_all;
   wire  [15:0] thresh_all = {thresh_ch1_ch2, short_threshold};

   for (genvar c = 0; c < 4; c++) begin : g_ch
      chan_diag_seq #(.RUN_CYC(RUN_CYC)) u_seq (
         .sys_clk            (sys_clk),
         .rst_b              (rst_b),
         .req_state          (chan_state_req[2*c +: 2]),
         .auto_diag_disable  (auto_diag_disable),
         .diag_abort_request (diag_abort_request),
         .line_diag_enable   (line_diag_enable),
         .fault_seen         (f_stable[c+4] | f_stable[c]),
         .short_threshold    (thresh_all[4*c +: 4]),
         .meas_load          (meas_load[4*c +: 4]),
         .meas_flags         (meas_flags[4*c +: 4]),
         .result             (results[4*c +: 4]),
         .line_out           (line_found[c]),
         .state_rb           (state_all[2*c +: 2])
      );
   end

   //==========================================================================
   // Register decode and read mux
   wire hit_thresh = (reg_addr == `ADDR_THRESH_34);
   wire [7:0] rd_mux =
      (reg_addr == `ADDR_THRESH_34) ? short_threshold :
      (reg_addr == `ADDR_RESULT_12) ? results[15:8] :
      (reg_addr == `ADDR_RESULT_34) ? results[7:0] :
      (reg_addr == `ADDR_LINE_OUT)  ? {4'h0, line_found} :
      (reg_addr == `ADDR_STATE_RB)  ? state_all :
      (reg_addr == `ADDR_CH_FAULT)  ? f_stable :
      8'h00;

   // Only the threshold register accepts writes; the rest ignore them
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         short_threshold <= `RST_THRESH_34;
      end else if (reg_wr && hit_thresh) begin
         short_threshold <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `RST_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end
endmodule

// *** bench/load_diag_regs_asserts.sv ***
// Port-level assertions for the load diagnostics register bank
//==========================================================================
// Checker
module load_diag_regs_chk (
   input wire logic       sys_clk,            // Clock
   input wire logic       rst_b,              // Reset
   input wire logic [7:0] reg_addr,           // Address
   input wire logic       reg_wr,             // Write
   input wire logic [7:0] reg_wdata,          // Write data
   input wire logic       reg_rd,             // Read
   input wire logic [7:0] reg_rdata,          // Read data
   input wire logic [7:0] chan_state_req,     // Requested states
   input wire logic       diag_abort_request, // Abort
   input wire logic [3:0] overcurrent_in,     // Overcurrent pins
   input wire logic [3:0] dc_fault_in,        // DC pins
   input wire logic [7:0] short_threshold     // Threshold register
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire thr_wr = reg_wr && reg_addr == 8'h0B;
   thresh_wr_a: assert property (thr_wr |=> short_threshold == $past(reg_wdata))
      else $error("threshold write not taken");
   thresh_hold_a: assert property (!thr_wr |=> $stable(short_threshold))
      else $error("threshold changed without write");
   thresh_read_a: assert property (reg_rd && !reg_wr && reg_addr == 8'h0B
      |=> reg_rdata == short_threshold)
      else $error("threshold read wrong");
   line_rsvd_a: assert property (reg_rd && reg_addr == 8'h0E |=> reg_rdata[7:4] == 4'h0)
      else $error("line result upper bits set");
   unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h0B || reg_addr > 8'h10) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   fault_flags_a: assert property ($stable({overcurrent_in, dc_fault_in})[*5]
      ##0 (reg_rd && reg_addr == 8'h10)
      |=> reg_rdata == {$past(overcurrent_in), $past(dc_fault_in)})
      else $error("fault flags differ from pins");
   diag_state_a: assert property ($changed(chan_state_req[1:0])
      && chan_state_req[1:0] == 2'h3 && !diag_abort_request
      ##1 reg_rd && reg_addr == 8'h0F |=> reg_rdata[1:0] == 2'h3)
      else $error("run not shown in read-back");
   cover property (thr_wr);
   cover property (reg_rd && reg_addr == 8'h0F);
   cover property (reg_rd && reg_addr == 8'h10);
endmodule
bind load_diag_regs load_diag_regs_chk i_chk (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata,
   .reg_rd, .reg_rdata, .chan_state_req, .diag_abort_request, .overcurrent_in, .dc_fault_in,
   .short_threshold);

// *** bench/load_diag_regs_tb.sv ***
// Directed testbench for the load diagnostics register bank
module load_diag_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        auto_diag_disable = 1'b0, diag_abort_request = 1'b0, line_diag_enable = 1'b1;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, short_threshold;
   logic [7:0]  chan_state_req = 8'h55;
   logic [15:0] meas_load = 16'hFFF0, meas_flags = 16'h8421;
   logic [3:0]  overcurrent_in = 4'h0, dc_fault_in = 4'h0;
   logic [7:0]  rst_vals [6] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00};
   int          err_count = 0, samples_checked = 0, i;
   load_diag_regs #(.RUN_CYC(4)) i_dut (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata, .chan_state_req, .auto_diag_disable, .diag_abort_request,
      .line_diag_enable, .meas_load, .meas_flags, .overcurrent_in, .dc_fault_in,
      .thresh_ch1_ch2(8'h11), .short_threshold);
   initial forever #4 sys_clk = ~sys_clk;
   //=======================================================================
   // Access tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      samples_checked++;
      if (reg_rdata !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, reg_rdata, e);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   //=======================================================================
   // Tests
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (i = 0; i < 6; i++) rd(8'(8'h0B + i), rst_vals[i]);
      rd(8'h11, 8'h00);
      wr(8'h0B, 8'h90);
      rd(8'h0B, 8'h90);
      wr(8'h0B, 8'h09);
      rd(8'h0B, 8'h09);
      wr(8'h0B, 8'h11);
      for (i = 0; i < 5; i++) wr(8'(8'h0C + i), 8'hFF);
      for (i = 0; i < 6; i++) rd(8'(8'h0B + i), rst_vals[i]);
      $display("test registers finished");
      @(posedge sys_clk);
      chan_state_req <= 8'hFF;
      rd(8'h0F, 8'hFF);
      repeat (10) @(posedge sys_clk);
      meas_flags <= 16'h0000;
      rd(8'h0C, 8'h84);
      rd(8'h0D, 8'h21);
      rd(8'h0E, 8'h01);
      rd(8'h0F, 8'h55);
      $display("test diagnostics finished");
      @(posedge sys_clk);
      chan_state_req <= 8'h55;
      @(posedge sys_clk);
      chan_state_req <= 8'h00;
      @(posedge sys_clk);
      diag_abort_request <= 1'b1;
      rd(8'h0F, 8'h00);
      // Wait past where an unaborted run would have latched zero ch1/ch2 results
      repeat (4) @(posedge sys_clk);
      rd(8'h0C, 8'h84);
      $display("test abort finished");
      @(posedge sys_clk);
      diag_abort_request <= 1'b0;
      auto_diag_disable <= 1'b1;
      chan_state_req <= 8'h55;
      @(posedge sys_clk);
      chan_state_req <= 8'hAA;
      overcurrent_in <= 4'hA;
      dc_fault_in <= 4'h5;
      rd(8'h0F, 8'hAA);
      repeat (4) @(posedge sys_clk);
      rd(8'h10, 8'hA5);
      $display("test faults finished");
      @(posedge sys_clk);
      line_diag_enable <= 1'b0;
      meas_flags <= 16'h0001;
      chan_state_req <= 8'hFF;
      rd(8'h0F, 8'hFF);
      repeat (8) @(posedge sys_clk);
      rd(8'h0E, 8'h00);
      rd(8'h0D, 8'h01);
      $display("test line disable finished");
      auto_diag_disable <= 1'b0;
      chan_state_req <= 8'h00;
      overcurrent_in <= 4'h0;
      dc_fault_in <= 4'h0;
      repeat (8) @(posedge sys_clk);
      meas_flags <= 16'h4000;
      overcurrent_in <= 4'h8;
      repeat (14) @(posedge sys_clk);
      rd(8'h0C, 8'h40);
      $display("test fault run finished");
      wr(8'h0B, 8'h23);
      rd(8'h0B, 8'h23);
      @(posedge sys_clk);
      auto_diag_disable <= 1'b1;
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(8'h0B, 8'h11);
      rd(8'h0C, 8'h00);
      rd(8'h0F, 8'h00);
      $display("test reset finished");
      complete_run();
   end
   // Whole run is under two hundred cycles
   initial begin
      #(4000 * 8);
      err_count++;
      complete_run();
   end
endmodule
